// [hdl/ecr_top.sv]
// Overview of operation
// - Writing one to bit 15 lets the next write change protected bits.
// - The unlock bit clears itself after the following management write, unless that write sets bit 15 again.
// - Reserved bits 14:11, 4 and 1 always read as zero.
// - Address bits 10:6 capture the LED pins at hardware reset.
// - Software reset leaves the captured address unchanged.
// - Bit 5 forces descrambler out of lock; resets to zero.
// - Bit 3 selects NRZ (0) or NRZI (1) at 100 Mb/s; resets one.
// - Bit 2 clear gives standard 4B/5B transmit translation.
// - Invalid mode with error line: nibbles 0-7 sent as zero plus nibble.
// - Invalid mode with error line: nibbles 8-F use the fixed code list.
// - Bit 0 set bypasses scrambler and descrambler; resets to zero.
// - The scrambler is used only at 100 Mb/s.
`timescale 1ns/1ps
`default_nettype none
module ecr_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  input wire logic mgmt_wr_i,
  input wire logic mgmt_rd_i,
  input wire logic [4:0] mgmt_reg_addr_i,
  input wire logic [ecr_pkg::ECR_DATA_W-1:0] mgmt_wdata_i,
  output logic [ecr_pkg::ECR_DATA_W-1:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o,
  output logic override_protected_bit_wr_en_o,
  input wire logic addr4_led_pin_i,
  input wire logic addr3_led_pin_i,
  input wire logic addr2_led_pin_i,
  input wire logic addr1_led_pin_i,
  input wire logic addr0_led_pin_i,
  output logic [ecr_pkg::ECR_ADDR_W-1:0] phy_addr_o,
  output logic phy_addr_valid_o,
  input wire logic speed_100_i,
  output logic scrambler_en_o,
  output logic descrambler_force_unlock_o,
  input wire logic tx_nib_en_i,
  input wire logic [3:0] tx_nibble_i,
  input wire logic tx_er_i,
  output logic [4:0] tx_code_o,
  input wire logic tx_bit_en_i,
  input wire logic tx_bit_i,
  output logic tx_line_o
);
  import ecr_pkg::*;

  logic unlock_reg;
  logic scr_test_reg;
  logic nrzi_reg;
  logic inv_code_reg;
  logic cipher_dis_reg;
  logic [ECR_ADDR_W-1:0] addr_reg;
  ecr_addr_state_t addr_state_reg;
  logic [ECR_DATA_W-1:0] rdata_reg;
  logic rvalid_reg;
  logic scr_en_reg;
  logic desc_unlock_reg;
  logic line_reg;
  logic hit;
  logic wr_hit;
  logic wr_other;
  logic [ECR_DATA_W-1:0] reg_view;
  ecr_enc_if enc_bus ();

  assign hit = mgmt_reg_addr_i == ECR_REG_ADDR;
  assign wr_hit = mgmt_wr_i & hit;
  assign wr_other = mgmt_wr_i & ~hit;

  ////////////////////////////////////////////////////////////////////////
  // Override unlock
  // unlock set and clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      unlock_reg <= ECR_UNLOCK_RST;
    end else if (soft_reset_i) begin
      unlock_reg <= ECR_UNLOCK_RST;
    end else if (wr_hit) begin
      unlock_reg <= mgmt_wdata_i[ECR_UNLOCK_BIT];
    end else if (wr_other) begin
      unlock_reg <= 1'b0;
    end
  end

  assign override_protected_bit_wr_en_o = unlock_reg;

  ////////////////////////////////////////////////////////////////////////
  // Writable control fields
  // field write
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scr_test_reg <= ECR_SCR_TEST_RST;
      nrzi_reg <= ECR_NRZI_RST;
      inv_code_reg <= ECR_INV_CODE_RST;
      cipher_dis_reg <= ECR_CIPHER_DIS_RST;
    end else if (soft_reset_i) begin
      scr_test_reg <= ECR_SCR_TEST_RST;
      nrzi_reg <= ECR_NRZI_RST;
      inv_code_reg <= ECR_INV_CODE_RST;
      cipher_dis_reg <= ECR_CIPHER_DIS_RST;
    end else if (wr_hit) begin
      scr_test_reg <= mgmt_wdata_i[ECR_SCR_TEST_BIT];
      nrzi_reg <= mgmt_wdata_i[ECR_NRZI_BIT];
      inv_code_reg <= mgmt_wdata_i[ECR_INV_CODE_BIT];
      cipher_dis_reg <= mgmt_wdata_i[ECR_CIPHER_DIS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address capture, first edge after hardware reset release
  // address latch
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_reg <= '0;
      addr_state_reg <= ECR_ADDR_WAIT;
    end else begin
      case (addr_state_reg)
        ECR_ADDR_WAIT: begin
          addr_reg <= {addr4_led_pin_i, addr3_led_pin_i, addr2_led_pin_i,
                       addr1_led_pin_i, addr0_led_pin_i};
          addr_state_reg <= ECR_ADDR_HELD;
        end
        ECR_ADDR_HELD: begin
          addr_reg <= addr_reg;
        end
        default: begin
          addr_state_reg <= ECR_ADDR_WAIT;
        end
      endcase
    end
  end

  assign phy_addr_o = addr_reg;
  assign phy_addr_valid_o = addr_state_reg == ECR_ADDR_HELD;

  ////////////////////////////////////////////////////////////////////////
  // Read path
  // reserved read zero
  always_comb begin
    reg_view = '0;
    reg_view[ECR_UNLOCK_BIT] = unlock_reg;
    reg_view[ECR_ADDR_LSB +: ECR_ADDR_W] = addr_reg;
    reg_view[ECR_SCR_TEST_BIT] = scr_test_reg;
    reg_view[ECR_NRZI_BIT] = nrzi_reg;
    reg_view[ECR_INV_CODE_BIT] = inv_code_reg;
    reg_view[ECR_CIPHER_DIS_BIT] = cipher_dis_reg;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= mgmt_rd_i;
      if (mgmt_rd_i) begin
        rdata_reg <= hit ? reg_view : '0;
      end
    end
  end

  assign mgmt_rdata_o = rdata_reg;
  assign mgmt_rvalid_o = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////
  // Scrambler controls
  // scrambler gating
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scr_en_reg <= 1'b0;
      desc_unlock_reg <= 1'b0;
    end else begin
      scr_en_reg <= speed_100_i & ~cipher_dis_reg;
      desc_unlock_reg <= scr_test_reg;
    end
  end

  assign scrambler_en_o = scr_en_reg;
  assign descrambler_force_unlock_o = desc_unlock_reg;

  ////////////////////////////////////////////////////////////////////////
  // Serial line coding
  // NRZ or NRZI
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      line_reg <= 1'b0;
    end else if (tx_bit_en_i) begin
      if (speed_100_i && nrzi_reg) begin
        line_reg <= line_reg ^ tx_bit_i;
      end else begin
        line_reg <= tx_bit_i;
      end
    end
  end

  assign tx_line_o = line_reg;

  ////////////////////////////////////////////////////////////////////////
  // Transmit nibble coding
  assign enc_bus.nib_en = tx_nib_en_i;
  assign enc_bus.nibble = tx_nibble_i;
  assign enc_bus.tx_er = tx_er_i;
  assign enc_bus.invalid_mode = inv_code_reg;
  assign tx_code_o = enc_bus.code;

  ecr_encoder u_encoder (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .enc(enc_bus.enc_mp)
  );

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_unlock_write;
    wr_hit && mgmt_wdata_i[ECR_UNLOCK_BIT] && !soft_reset_i;
  endsequence

  sequence s_next_write;
    wr_other && !soft_reset_i;
  endsequence

  sequence s_field_write;
    wr_hit && !soft_reset_i;
  endsequence

  unlock_set_a: assert property (
    s_unlock_write |=> override_protected_bit_wr_en_o)
    else $error("unlock not granted after write of one");
  unlock_clear_a: assert property (
    override_protected_bit_wr_en_o ##0 s_next_write
    |=> !override_protected_bit_wr_en_o)
    else $error("unlock survived the following write");
  reserved_zero_a: assert property (
    mgmt_rvalid_o |-> (mgmt_rdata_o & ECR_RESERVED_MASK) == 16'h0000)
    else $error("reserved bits read nonzero");
  addr_hold_a: assert property (
    phy_addr_valid_o |=> phy_addr_valid_o && $stable(phy_addr_o))
    else $error("captured address changed");
  soft_keep_a: assert property (
    soft_reset_i && phy_addr_valid_o |=> $stable(phy_addr_o)
    ##0 !override_protected_bit_wr_en_o)
    else $error("software reset disturbed address or kept unlock");
  scr_test_a: assert property (
    s_field_write ##0 mgmt_wdata_i[ECR_SCR_TEST_BIT]
    |-> ##2 descrambler_force_unlock_o)
    else $error("scrambler test did not force unlock");
  nrz_line_a: assert property (
    tx_bit_en_i && !nrzi_reg |=> tx_line_o == $past(tx_bit_i))
    else $error("NRZ line does not follow data");
  nrzi_line_a: assert property (
    tx_bit_en_i && nrzi_reg && speed_100_i && tx_bit_i
    |=> tx_line_o != $past(tx_line_o))
    else $error("NRZI line did not invert on one");
  cipher_off_a: assert property (
    cipher_dis_reg [*2] |-> !scrambler_en_o)
    else $error("scrambler active while disabled");
  slow_off_a: assert property (
    !speed_100_i |=> !scrambler_en_o)
    else $error("scrambler active at 10 Mb/s");
  ro_write_a: assert property (
    wr_hit && phy_addr_valid_o |=> $stable(phy_addr_o))
    else $error("address bits took a write");
  unlock_self_a: assert property (
    wr_hit && !mgmt_wdata_i[ECR_UNLOCK_BIT]
    |=> !override_protected_bit_wr_en_o)
    else $error("unlock kept after write of zero");
  unlock_hold_a: assert property (
    override_protected_bit_wr_en_o && !mgmt_wr_i && !soft_reset_i
    |=> override_protected_bit_wr_en_o)
    else $error("unlock dropped with no write");
  unlock_zero_a: assert property (
    !override_protected_bit_wr_en_o && !mgmt_wr_i
    |=> !override_protected_bit_wr_en_o)
    else $error("unlock rose with no write");
  soft_fields_a: assert property (
    soft_reset_i
    |=> nrzi_reg && !scr_test_reg && !inv_code_reg && !cipher_dis_reg)
    else $error("software reset left fields off default");
  scr_write_a: assert property (
    s_field_write
    |=> scr_test_reg == $past(mgmt_wdata_i[ECR_SCR_TEST_BIT]))
    else $error("scrambler test bit did not take write");
  nrzi_write_a: assert property (
    s_field_write
    |=> nrzi_reg == $past(mgmt_wdata_i[ECR_NRZI_BIT]))
    else $error("line coding bit did not take write");
  inv_write_a: assert property (
    s_field_write
    |=> inv_code_reg == $past(mgmt_wdata_i[ECR_INV_CODE_BIT]))
    else $error("invalid code bit did not take write");
  cipher_write_a: assert property (
    s_field_write
    |=> cipher_dis_reg == $past(mgmt_wdata_i[ECR_CIPHER_DIS_BIT]))
    else $error("cipher disable bit did not take write");
  cipher_on_a: assert property (
    reset_n_i && speed_100_i && !cipher_dis_reg |=> scrambler_en_o)
    else $error("scrambler idle at 100 Mb/s while enabled");
  desc_normal_a: assert property (
    !scr_test_reg |=> !descrambler_force_unlock_o)
    else $error("descrambler held out of lock in normal mode");
  addr_capture_a: assert property (
    $rose(phy_addr_valid_o) |-> phy_addr_o == {$past(addr4_led_pin_i),
    $past(addr3_led_pin_i), $past(addr2_led_pin_i),
    $past(addr1_led_pin_i), $past(addr0_led_pin_i)})
    else $error("address not taken from the pins");
  read_other_a: assert property (
    mgmt_rd_i && !hit |=> mgmt_rvalid_o && mgmt_rdata_o == 16'h0000)
    else $error("unmapped read did not return zero");
endmodule
`default_nettype wire

// [hdl/ecr_pkg.sv]
package ecr_pkg;
  // Register map and field layout
  localparam logic [4:0] ECR_REG_ADDR = 5'h10;
  localparam int ECR_DATA_W = 16;
  localparam int ECR_UNLOCK_BIT = 15;
  localparam int ECR_ADDR_LSB = 6;
  localparam int ECR_ADDR_W = 5;
  localparam int ECR_SCR_TEST_BIT = 5;
  localparam int ECR_NRZI_BIT = 3;
  localparam int ECR_INV_CODE_BIT = 2;
  localparam int ECR_CIPHER_DIS_BIT = 0;
  localparam logic [15:0] ECR_RESERVED_MASK = 16'h7812;
  // Reset values of the writable fields
  localparam logic ECR_UNLOCK_RST = 1'b0;
  localparam logic ECR_SCR_TEST_RST = 1'b0;
  localparam logic ECR_NRZI_RST = 1'b1;
  localparam logic ECR_INV_CODE_RST = 1'b0;
  localparam logic ECR_CIPHER_DIS_RST = 1'b0;
  localparam logic [15:0] ECR_RESET_VALUE = 16'h0008;
  // Transmit code tables, indexed by nibble
  localparam logic [15:0][4:0] ECR_STD_CODE = {
    5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
    5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};
  localparam logic [15:0][4:0] ECR_INV_CODE = {
    5'h1F, 5'h18, 5'h19, 5'h10, 5'h11, 5'h0C, 5'h0D, 5'h00,
    5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  typedef enum logic [1:0] {
    ECR_ADDR_WAIT = 2'b01,
    ECR_ADDR_HELD = 2'b10
  } ecr_addr_state_t;
endpackage

// [hdl/ecr_enc_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ecr_enc_if;
  logic nib_en;
  logic [3:0] nibble;
  logic tx_er;
  logic invalid_mode;
  logic [4:0] code;
  modport enc_mp (
    input nib_en,
    input nibble,
    input tx_er,
    input invalid_mode,
    output code
  );
  modport ctl_mp (
    output nib_en,
    output nibble,
    output tx_er,
    output invalid_mode,
    input code
  );
endinterface
`default_nettype wire

// [hdl/ecr_encoder.sv]
`timescale 1ns/1ps
`default_nettype none
module ecr_encoder (
  input wire logic clk_i,
  input wire logic reset_n_i,
  ecr_enc_if.enc_mp enc
);
  import ecr_pkg::*;

  logic use_inv;

  assign use_inv = enc.invalid_mode & enc.tx_er;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enc.code <= 5'h00;
    end else if (enc.nib_en) begin
      if (use_inv) begin
        enc.code <= ECR_INV_CODE[enc.nibble];
      end else begin
        enc.code <= ECR_STD_CODE[enc.nibble];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  inv_low_a: assert property (
    enc.nib_en && use_inv && !enc.nibble[3]
    |=> enc.code == {1'b0, $past(enc.nibble)})
    else $error("low nibble not passed through in invalid mode");
  inv_high_a: assert property (
    enc.nib_en && use_inv && enc.nibble == 4'h9 |=> enc.code == 5'h0D)
    else $error("nibble 1001 not sent as 01101");
  std_keep_a: assert property (
    enc.nib_en && enc.invalid_mode && !enc.tx_er && enc.nibble == 4'h0
    |=> enc.code == 5'h1E)
    else $error("standard code lost while error line low");
  std_map_a: assert property (
    enc.nib_en && !enc.invalid_mode && enc.nibble == 4'h4
    |=> enc.code == 5'h0A)
    else $error("standard translation wrong");
endmodule
`default_nettype wire

// [verif/ecr_sta_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ecr_sta_model (
  input wire logic clk_i,
  input wire logic [ecr_pkg::ECR_DATA_W-1:0] rdata_i,
  input wire logic rvalid_i,
  output logic wr_o,
  output logic rd_o,
  output logic [4:0] addr_o,
  output logic [ecr_pkg::ECR_DATA_W-1:0] wdata_o
);
  import ecr_pkg::*;
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] m;
    m = (a == ECR_REG_ADDR) ? (d & ~ECR_RESERVED_MASK) : d;
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= m;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~m;
    // Let the written fields settle before the caller looks
    #1;
  endtask
  task automatic unlock_wr(input logic [4:0] a, input logic [15:0] d);
    wr(ECR_REG_ADDR, 16'h8008);
    wr(a, d);
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ecr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic srst = 1'b0;
  logic spd = 1'b1;
  logic nen = 1'b0;
  logic er = 1'b0;
  logic ben = 1'b0;
  logic bi = 1'b0;
  logic [3:0] nib = 4'h0;
  logic [4:0] led = 5'h15;
  logic [4:0] cap = 5'h15;
  logic wr, rd, rv, wen, av, scr, dsu, ln, v;
  logic [4:0] ra, pa, code;
  logic [15:0] wd, rdat, d;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  ecr_top u_ecr_top (.clk_i(clk), .reset_n_i(rst_n), .soft_reset_i(srst),
    .mgmt_wr_i(wr), .mgmt_rd_i(rd), .mgmt_reg_addr_i(ra),
    .mgmt_wdata_i(wd), .mgmt_rdata_o(rdat), .mgmt_rvalid_o(rv),
    .override_protected_bit_wr_en_o(wen), .addr4_led_pin_i(led[4]),
    .addr3_led_pin_i(led[3]), .addr2_led_pin_i(led[2]),
    .addr1_led_pin_i(led[1]), .addr0_led_pin_i(led[0]),
    .phy_addr_o(pa), .phy_addr_valid_o(av), .speed_100_i(spd),
    .scrambler_en_o(scr), .descrambler_force_unlock_o(dsu),
    .tx_nib_en_i(nen), .tx_nibble_i(nib), .tx_er_i(er), .tx_code_o(code),
    .tx_bit_en_i(ben), .tx_bit_i(bi), .tx_line_o(ln));
  ecr_sta_model u_ecr_sta_model (.clk_i(clk), .rdata_i(rdat),
    .rvalid_i(rv), .wr_o(wr), .rd_o(rd), .addr_o(ra), .wdata_o(wd));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict;
    end
  end
  task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
    u_ecr_sta_model.rd(a, d, v);
    chk("rvalid", 16'h1, {15'h0, v});
    chk("rdata", e, d);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(ECR_REG_ADDR, {5'h0, cap, 6'h08});
    chk("phy_addr", {11'h0, cap}, {11'h0, pa});
    chk("addr_valid", 16'h1, {15'h0, av});
    chk("unlock", 16'h0, {15'h0, wen});
    chk("scr_en", 16'h1, {15'h0, scr});
  endtask
  task automatic t_fields;
    u_ecr_sta_model.wr(ECR_REG_ADDR, 16'h7FFF);
    rdchk(ECR_REG_ADDR, {5'h0, cap, 6'h2D});
    chk("scr_en", 16'h0, {15'h0, scr});
    chk("force_unlock", 16'h1, {15'h0, dsu});
    rdchk(5'h11, 16'h0000);
  endtask
  task automatic t_unlock;
    u_ecr_sta_model.wr(ECR_REG_ADDR, 16'h8008);
    chk("unlock_set", 16'h1, {15'h0, wen});
    u_ecr_sta_model.wr(5'h00, 16'h0000);
    chk("unlock_other", 16'h0, {15'h0, wen});
    u_ecr_sta_model.unlock_wr(ECR_REG_ADDR, 16'h0008);
    chk("unlock_self", 16'h0, {15'h0, wen});
  endtask
  task automatic t_nib;
    logic [4:0] hi [8] = '{5'h00, 5'h0D, 5'h0C, 5'h11,
                           5'h10, 5'h19, 5'h18, 5'h1F};
    logic [4:0] e;
    for (int m = 0; m < 3; m++) begin
      u_ecr_sta_model.wr(ECR_REG_ADDR, (m == 0) ? 16'h0008 : 16'h000C);
      for (int i = 0; i < 16; i++) begin
        e = (i < 8) ? {1'b0, i[3:0]} : hi[i-8];
        if (m < 2)
          e = ECR_STD_CODE[i];
        @(posedge clk);
        nen <= 1'b1;
        nib <= i[3:0];
        er <= (m != 1);
        @(posedge clk);
        nen <= 1'b0;
        #1;
        chk("tx_code", {11'h0, e}, {11'h0, code});
      end
    end
  endtask
  task automatic sb(input logic b, input logic e);
    @(posedge clk);
    ben <= 1'b1;
    bi <= b;
    @(posedge clk);
    ben <= 1'b0;
    bi <= ~b;
    #1;
    chk("tx_line", {15'h0, e}, {15'h0, ln});
  endtask
  task automatic t_line;
    u_ecr_sta_model.wr(ECR_REG_ADDR, 16'h0000);
    sb(1'b1, 1'b1);
    sb(1'b0, 1'b0);
    u_ecr_sta_model.wr(ECR_REG_ADDR, 16'h0008);
    sb(1'b1, 1'b1);
    sb(1'b1, 1'b0);
    sb(1'b0, 1'b0);
    sb(1'b1, 1'b1);
    @(posedge clk);
    spd <= 1'b0;
    sb(1'b1, 1'b1);
    sb(1'b1, 1'b1);
    chk("scr_10m", 16'h0, {15'h0, scr});
    @(posedge clk);
    spd <= 1'b1;
  endtask
  task automatic t_soft;
    u_ecr_sta_model.wr(ECR_REG_ADDR, 16'h8025);
    @(posedge clk);
    srst <= 1'b1;
    led <= 5'h0A;
    @(posedge clk);
    srst <= 1'b0;
    rdchk(ECR_REG_ADDR, {5'h0, cap, 6'h08});
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cap = 5'h0A;
    repeat (2) @(posedge clk);
    t_reset;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_fields;
    t_unlock;
    t_nib;
    t_line;
    t_soft;
    print_verdict;
  end
endmodule
`default_nettype wire
